// ==== bldc_pkg.sv ====
// Shared constants and pin, fault, gate and mode types of the brushless drive control block
package bldc_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 20;
   localparam int REF_NOM_MHZ = 5;
   localparam int DEAD_REF_PERIODS = 6;
   localparam int CP_DIVIDE = 16;
   localparam int CP_W = $clog2(CP_DIVIDE);
   localparam int CARRIER_PERIOD = 248;
   localparam int CARRIER_HALF = CARRIER_PERIOD / 2;
   localparam int DUTY_UNIT_CYC = CLK_MHZ / REF_NOM_MHZ;
   localparam int DUTY_TIMEOUT_UNITS = 1000;
   localparam int FTV_HOLD_US = 13100;
   localparam int FTV_HOLD_CYC = FTV_HOLD_US * CLK_MHZ;
   localparam int FTV_HOLD_W = 20;
   localparam int HALL_PER_W = 21;
   localparam int LEAD_UPDATE_CYCLES = 16;
   localparam logic [4:0] LEAD_MAX_STEP = 5'h0F;

   // ------------------------------------------------------------
   // Values after reset and full-scale duty
   // ------------------------------------------------------------
   localparam logic [2:0] HALL_RESET = 3'h0;
   localparam logic [7:0] DUTY_RESET = 8'h00;
   localparam logic [7:0] DUTY_FULL = 8'hFF;
   localparam logic [3:0] LEAD_RESET = 4'h0;
   localparam logic DIR_RESET = 1'b1;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic start_n;
      logic brake_n;
      logic rotation_dir;
      logic speed_cmd_n;
   } bldc_pins_s;

   typedef struct packed {
      logic undervolt;
      logic thermal;
      logic bounce;
      logic overcur;
   } bldc_fault_s;

   typedef struct packed {
      logic [2:0] hi;
      logic [2:0] lo;
   } bldc_gate_s;

   typedef enum logic [1:0] {
      MODE_STANDBY = 2'b00,
      MODE_NORMAL = 2'b01,
      MODE_BRAKE = 2'b10,
      MODE_OFF = 2'b11
   } bldc_mode_e;

endpackage : bldc_pkg

// ==== bldc_dead_time.sv ====
// Dead interval insertion for one half bridge
`timescale 1ns/1ps
`default_nettype none
module bldc_dead_time #(
   parameter int DEAD_CYC = bldc_pkg::DEAD_REF_PERIODS
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [1:0] want,
   output logic [1:0] drive
);
   import bldc_pkg::*;

   initial begin
      if (DEAD_CYC < 1 || DEAD_CYC > 15) begin
         $error("DEAD_CYC must be 1 to 15");
      end
   end

   localparam logic [3:0] DEAD_LOAD = 4'(DEAD_CYC - 1);

   logic [3:0] cnt;
   wire logic drop = (drive != 2'b00) && (want != drive);
   wire logic take = (drive == 2'b00) && (cnt == 4'h0);

   // Any switch-off opens a full dead interval before the next switch-on
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         drive <= 2'b00;
         cnt <= 4'h0;
      end else if (drop) begin
         drive <= 2'b00;
         cnt <= DEAD_LOAD;
      end else if (take) begin
         drive <= want;
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end
   end

   a_dead_gap: assert property (@(posedge core_clk) disable iff (rst)
      (drive == 2'b00 && $past(drive) != 2'b00) |-> (drive == 2'b00)[*6])
      else $error("dead interval shorter than six cycles");

endmodule : bldc_dead_time
`default_nettype wire

// ==== bldc_drive_control.sv ====
// Gate drive, hall, mode, speed command and lead angle control logic
`timescale 1ns/1ps
`default_nettype none
module bldc_drive_control #(
   parameter int FTV_HOLD = bldc_pkg::FTV_HOLD_CYC,
   parameter int DEAD_CYC = bldc_pkg::DEAD_REF_PERIODS
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire bldc_pkg::bldc_pins_s pins,
   input wire logic hall_phase_a,
   input wire logic hall_phase_b,
   input wire logic hall_phase_c,
   input wire logic hall_open_raw,
   input wire bldc_pkg::bldc_fault_s fault_raw,
   input wire logic mode_180,
   input wire bldc_pkg::bldc_gate_s drive_req,
   input wire logic [4:0] lead_angle_in,
   output var bldc_pkg::bldc_gate_s gate,
   output logic gate_oe,
   output logic charge_pump_clk,
   output logic hall_pulse_out,
   output logic hall_pulse_oe,
   output logic [2:0] hall_latched,
   output logic rotation_dir,
   output logic standby_state,
   output var bldc_pkg::bldc_mode_e drive_mode,
   output logic [7:0] cmd_duty,
   output logic duty_zero,
   output logic lock_release,
   output logic freq_to_voltage_out,
   output logic [3:0] lead_angle_step
);
   import bldc_pkg::*;

   initial begin
      if (FTV_HOLD < 1 || FTV_HOLD >= (1 << FTV_HOLD_W)) begin
         $error("FTV_HOLD out of range");
      end
   end

   localparam logic [FTV_HOLD_W-1:0] FTV_HOLD_V = FTV_HOLD_W'(FTV_HOLD);
   localparam logic [7:0] CAR_LAST = 8'(CARRIER_PERIOD - 1);
   localparam logic [7:0] CAR_HALF = 8'(CARRIER_HALF);
   localparam logic [3:0] UNIT_LAST = 4'(DUTY_UNIT_CYC - 1);
   localparam logic [9:0] IDLE_MAX = 10'(DUTY_TIMEOUT_UNITS);
   localparam logic [3:0] LEAD_LAST = 4'(LEAD_UPDATE_CYCLES - 1);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic hall_valid(input logic [2:0] h);
      hall_valid = (h != 3'b000) && (h != 3'b111);
   endfunction : hall_valid

   function automatic logic one_step(input logic [2:0] d);
      one_step = (d == 3'b001) || (d == 3'b010) || (d == 3'b100);
   endfunction : one_step

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [11:0] sync1;
   logic [11:0] sync2;
   bldc_pins_s pins_s;
   bldc_fault_s fault_s;
   logic hall_open_s;
   logic [2:0] hall_s;
   wire logic [11:0] async_in = {pins, fault_raw, hall_open_raw,
                                 hall_phase_c, hall_phase_b, hall_phase_a};

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync1 <= 12'hF00;
         sync2 <= 12'hF00;
      end else begin
         sync1 <= async_in;
         sync2 <= sync1;
      end
   end

   assign {pins_s, fault_s, hall_open_s, hall_s} = sync2;

   // ------------------------------------------------------------
   // Operating mode
   // ------------------------------------------------------------
   wire logic hard_off = fault_s.undervolt | fault_s.thermal;
   bldc_mode_e next_mode;
   bldc_gate_s want;
   logic carrier_on;

   // Bounce and overcurrent are left out on purpose: braking survives them
   assign next_mode = pins_s.start_n ? MODE_STANDBY :
                      hard_off ? MODE_OFF :
                      !pins_s.brake_n ? MODE_BRAKE :
                      duty_zero ? MODE_OFF :
                      MODE_NORMAL;

   always_comb begin
      case (drive_mode)
         MODE_NORMAL: begin
            want.hi = drive_req.hi & {3{carrier_on & ~fault_s.overcur}};
            want.lo = drive_req.lo & ~want.hi;
         end
         MODE_BRAKE: begin
            want.hi = 3'b000;
            want.lo = 3'b111;
         end
         default: begin
            want.hi = 3'b000;
            want.lo = 3'b000;
         end
      endcase
   end

   logic [2:0][1:0] pair;

   genvar ph;
   generate
      for (ph = 0; ph < 3; ph++) begin : g_phase
         bldc_dead_time #(
            .DEAD_CYC(DEAD_CYC)
         ) u_dead (
            .core_clk(core_clk),
            .rst(rst),
            .want({want.hi[ph], want.lo[ph]}),
            .drive(pair[ph])
         );
      end
   endgenerate

   assign gate.hi = {pair[2][1], pair[1][1], pair[0][1]};
   assign gate.lo = {pair[2][0], pair[1][0], pair[0][0]};
   assign hall_pulse_out = 1'b0;

   // ------------------------------------------------------------
   // Hall latch and hall pulse
   // ------------------------------------------------------------
   // In 180 mode a step is accepted only as a single-bit move to a legal code, or any legal code from an illegal latch
   wire logic hall_ok = hall_valid(hall_s) &&
                        (!hall_valid(hall_latched) ||
                         one_step(hall_s ^ hall_latched));
   wire logic [2:0] next_hall = !mode_180 ? hall_s :
                                hall_ok ? hall_s : hall_latched;
   logic pa_d;
   wire logic pa_rise = hall_latched[0] & ~pa_d;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         drive_mode <= MODE_STANDBY;
         hall_latched <= HALL_RESET;
         pa_d <= 1'b0;
         gate_oe <= 1'b0;
         hall_pulse_oe <= 1'b0;
         rotation_dir <= DIR_RESET;
         standby_state <= 1'b1;
      end else begin
         drive_mode <= next_mode;
         hall_latched <= next_hall;
         pa_d <= hall_latched[0];
         gate_oe <= ~hall_open_s;
         hall_pulse_oe <= ~pins_s.start_n & ~hall_latched[0];
         rotation_dir <= pins_s.rotation_dir;
         standby_state <= pins_s.start_n;
      end
   end

   // ------------------------------------------------------------
   // Charge pump clock and output carrier
   // ------------------------------------------------------------
   logic [CP_W-1:0] cp_cnt;
   logic [7:0] car_cnt;
   wire logic [7:0] tri_val = (car_cnt < CAR_HALF) ? car_cnt :
                              8'(CAR_LAST - car_cnt);

   // Carrier never looks at the command edges, only at the clock
   assign carrier_on = cmd_duty[7:1] > tri_val[6:0];
   assign charge_pump_clk = cp_cnt[CP_W-1];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cp_cnt <= '0;
         car_cnt <= 8'h00;
      end else begin
         cp_cnt <= cp_cnt + CP_W'(1);
         car_cnt <= (car_cnt == CAR_LAST) ? 8'h00 : car_cnt + 8'h01;
      end
   end

   // ------------------------------------------------------------
   // Speed command duty measurement
   // ------------------------------------------------------------
   logic [3:0] unit_cnt;
   logic cmd_d;
   logic [7:0] low_cnt;
   logic [9:0] idle_cnt;
   wire logic unit_tick = unit_cnt == UNIT_LAST;
   wire logic cmd_s = pins_s.speed_cmd_n;
   wire logic cmd_fall = cmd_d & ~cmd_s;
   wire logic cmd_rise = ~cmd_d & cmd_s;
   wire logic timeout = idle_cnt == IDLE_MAX;
   wire logic sample_vld = cmd_rise | timeout;
   // A stuck line reads as 0 % when high and 100 % when low
   wire logic [7:0] sample = cmd_rise ? low_cnt :
                             cmd_s ? DUTY_RESET : DUTY_FULL;
   wire logic [7:0] duty_diff = (sample > cmd_duty) ? 8'(sample - cmd_duty)
                                                    : 8'(cmd_duty - sample);
   // Zero is always taken so a stop is never filtered away
   wire logic jitter = mode_180 && (duty_diff <= 8'h01) &&
                       (sample != 8'h00);
   wire logic [7:0] next_duty = (sample_vld && !jitter) ? sample
                                                       : cmd_duty;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         unit_cnt <= 4'h0;
         cmd_d <= 1'b1;
         low_cnt <= 8'h00;
         idle_cnt <= 10'h000;
         cmd_duty <= DUTY_RESET;
         duty_zero <= 1'b1;
      end else begin
         unit_cnt <= unit_tick ? 4'h0 : unit_cnt + 4'h1;
         cmd_d <= cmd_s;
         if (cmd_fall) begin
            low_cnt <= 8'h00;
         end else if (!cmd_s && unit_tick && low_cnt != DUTY_FULL) begin
            low_cnt <= low_cnt + 8'h01;
         end
         if (cmd_fall || cmd_rise) begin
            idle_cnt <= 10'h000;
         end else if (unit_tick && !timeout) begin
            idle_cnt <= idle_cnt + 10'h001;
         end
         cmd_duty <= next_duty;
         duty_zero <= next_duty == 8'h00;
      end
   end

   assign lock_release = duty_zero;

   // ------------------------------------------------------------
   // Eight-times hall pulse and lead angle
   // ------------------------------------------------------------
   logic [FTV_HOLD_W-1:0] hold_cnt;
   logic [HALL_PER_W-1:0] per_cnt;
   logic [HALL_PER_W-1:0] period;
   logic [HALL_PER_W-1:0] oct_cnt;
   logic [3:0] lead_cyc;
   wire logic hold_full = hold_cnt == FTV_HOLD_V;
   wire logic ftv_en = mode_180 && hold_full;
   wire logic oct_hit = oct_cnt >= (period >> 3);
   wire logic lead_update = pa_rise && (lead_cyc == LEAD_LAST);
   wire logic [3:0] lead_clamp = (lead_angle_in > LEAD_MAX_STEP) ?
                                 LEAD_MAX_STEP[3:0] : lead_angle_in[3:0];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hold_cnt <= '0;
         per_cnt <= '0;
         period <= '0;
         oct_cnt <= '0;
         freq_to_voltage_out <= 1'b0;
         lead_cyc <= 4'h0;
         lead_angle_step <= LEAD_RESET;
      end else begin
         if (!mode_180) begin
            hold_cnt <= '0;
         end else if (!hold_full) begin
            hold_cnt <= hold_cnt + FTV_HOLD_W'(1);
         end
         if (pa_rise) begin
            period <= per_cnt;
            per_cnt <= '0;
         end else if (per_cnt != '1) begin
            per_cnt <= per_cnt + HALL_PER_W'(1);
         end
         oct_cnt <= (pa_rise || oct_hit) ? '0 : oct_cnt + HALL_PER_W'(1);
         freq_to_voltage_out <= ftv_en & (pa_rise | oct_hit);
         if (pa_rise) begin
            lead_cyc <= lead_cyc + 4'h1;
         end
         if (lead_update) begin
            lead_angle_step <= lead_clamp;
         end
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   a_cp_divide: assert property (
      $changed(charge_pump_clk) |=>
         $stable(charge_pump_clk)[*7] ##1 $changed(charge_pump_clk))
      else $error("charge pump clock not divided by sixteen");
   a_hiz_open: assert property (hall_open_s |=> !gate_oe)
      else $error("gates driven while halls open");
   a_hall_step: assert property (
      $past(mode_180) && $changed(hall_latched) |->
         hall_valid(hall_latched) && (!hall_valid($past(hall_latched)) ||
         one_step(hall_latched ^ $past(hall_latched))))
      else $error("inconsistent hall step latched");
   a_hall_bypass: assert property (
      !mode_180 |=> hall_latched == $past(hall_s))
      else $error("hall latch not bypassed in 120 mode");
   a_pulse_release: assert property (pins_s.start_n |=> !hall_pulse_oe)
      else $error("hall pulse driven in standby");
   a_brake_low: assert property (
      drive_mode == MODE_BRAKE [*8] |=>
         gate.lo == 3'b111 && gate.hi == 3'b000)
      else $error("brake did not turn on all lower gates");
   a_off_prio: assert property (
      hard_off |=> drive_mode != MODE_BRAKE ##1
         (gate.hi == 3'b000 && gate.lo == 3'b000))
      else $error("outputs not off on undervoltage or thermal");
   a_ftv_hold: assert property (
      freq_to_voltage_out |-> $past(mode_180) && $past(hold_full))
      else $error("eight-times pulse before hold expired");
   a_lead_update: assert property (
      $changed(lead_angle_step) |-> $past(lead_update))
      else $error("lead angle changed off its update slot");
   a_duty_stop: assert property (
      duty_zero && !pins_s.start_n && pins_s.brake_n && !hard_off |=>
         drive_mode == MODE_OFF)
      else $error("zero duty did not turn outputs off");

   c_brake: cover property (drive_mode == MODE_BRAKE ##8 gate.lo == 3'b111);
   c_ftv_pulse: cover property (freq_to_voltage_out);
   c_lead_update: cover property (lead_update);
   c_run: cover property (drive_mode == MODE_NORMAL && gate.hi != 3'b000);

endmodule : bldc_drive_control
`default_nettype wire

// ==== bldc_far_side.sv ====
// Far side model: hall sensor rotor and host speed command source
`timescale 1ns/1ps
`default_nettype none
module bldc_far_side (
   input wire logic core_clk,
   input wire logic hall_run,
   input wire logic [2:0] hall_hold,
   input wire logic [1:0] cmd_sel,
   input wire logic [7:0] cmd_low,
   output logic [2:0] hall,
   output logic speed_cmd_n
);
   // ----------------
   // Hall rotor
   // ----------------
   // Clockwise six-step code {c,b,a}: A leads B leads C, 40 clocks a step
   logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
   int step_cnt = 0;
   int idx = 0;
   int pwm_cnt = 0;

   always @(posedge core_clk) begin
      if (!hall_run) begin
         hall <= hall_hold;
      end else if (step_cnt == 39) begin
         step_cnt <= 0;
         idx <= (idx + 1) % 6;
         hall <= seq[(idx + 1) % 6];
      end else begin
         step_cnt <= step_cnt + 1;
      end
   end

   // ----------------
   // Speed command
   // ----------------
   // Period 1000 clocks, 250 units of 4; synchronous so each period
   // is measured alike
   always @(posedge core_clk) begin
      pwm_cnt <= (pwm_cnt == 999) ? 0 : pwm_cnt + 1;
      case (cmd_sel)
         2'h0: speed_cmd_n <= 1'b1;
         2'h1: speed_cmd_n <= 1'b0;
         default: speed_cmd_n <= (pwm_cnt >= 4 * int'(cmd_low));
      endcase
   end
endmodule : bldc_far_side
`default_nettype wire

// ==== bldc_drive_control_tb.sv ====
// Self-checking bench of the brushless drive control block
`timescale 1ns/1ps
`default_nettype none
module bldc_drive_control_tb;
   import bldc_pkg::*;
   // Short hold so the suppression window fits the run
   localparam int FTV_SIM = 50;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic start_n = 1'b1;
   logic brake_n = 1'b1;
   logic dir_pin = 1'b1;
   logic hall_open_raw = 1'b0;
   logic mode_180 = 1'b0;
   logic hall_run = 1'b0;
   logic [2:0] hall_hold = 3'h0;
   logic [1:0] cmd_sel = 2'h0;
   logic [7:0] cmd_low = 8'h00;
   logic [4:0] lead_angle_in = 5'h00;
   bldc_fault_s fault_raw = '0;
   bldc_gate_s drive_req = '0;
   wire logic [2:0] hall;
   wire logic speed_cmd_n;
   bldc_pins_s pins;
   bldc_gate_s gate;
   bldc_mode_e drive_mode;
   logic gate_oe, cp_clk, pulse_q, pulse_oe, dir_q, standby_q;
   logic dz, lock_rel, ftv_q;
   logic [2:0] hall_latched;
   logic [7:0] cmd_duty;
   logic [3:0] lead_step;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;
   int rises = 0;
   int exp_lead = 0;
   int ftv_cnt = 0;
   logic prev_a = 1'b0;

   assign pins = {start_n, brake_n, dir_pin, speed_cmd_n};
   always #25 core_clk = ~core_clk;

   bldc_far_side bldc_far_side_inst (
      .core_clk(core_clk), .hall_run(hall_run), .hall_hold(hall_hold),
      .cmd_sel(cmd_sel), .cmd_low(cmd_low), .hall(hall),
      .speed_cmd_n(speed_cmd_n)
   );

   bldc_drive_control #(
      .FTV_HOLD(FTV_SIM),
      .DEAD_CYC(DEAD_REF_PERIODS)
   ) bldc_drive_control_inst (
      .core_clk(core_clk), .rst(rst), .pins(pins),
      .hall_phase_a(hall[0]), .hall_phase_b(hall[1]),
      .hall_phase_c(hall[2]), .hall_open_raw(hall_open_raw),
      .fault_raw(fault_raw), .mode_180(mode_180),
      .drive_req(drive_req), .lead_angle_in(lead_angle_in),
      .gate(gate), .gate_oe(gate_oe), .charge_pump_clk(cp_clk),
      .hall_pulse_out(pulse_q), .hall_pulse_oe(pulse_oe),
      .hall_latched(hall_latched), .rotation_dir(dir_q),
      .standby_state(standby_q), .drive_mode(drive_mode),
      .cmd_duty(cmd_duty), .duty_zero(dz), .lock_release(lock_rel),
      .freq_to_voltage_out(ftv_q), .lead_angle_step(lead_step)
   );

   // ----------------
   // Reference model
   // ----------------
   function automatic bldc_mode_e exp_mode(input logic s_n,
         input logic b_n, input bldc_fault_s f, input logic zero);
      if (s_n) return MODE_STANDBY;
      if (f.undervolt || f.thermal) return MODE_OFF;
      if (!b_n) return MODE_BRAKE;
      return zero ? MODE_OFF : MODE_NORMAL;
   endfunction : exp_mode

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      prev_a <= hall_latched[0];
      if (ftv_q === 1'b1) ftv_cnt <= ftv_cnt + 1;
      if (hall_latched[0] === 1'b1 && prev_a === 1'b0) begin
         rises <= rises + 1;
         if ((rises + 1) % 16 == 0) begin
            exp_lead <= (lead_angle_in > 5'h0F) ? 15 : int'(lead_angle_in);
         end
      end
      if (cycles == 60000) begin
         mismatches++;
         complete_run();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic settle(input int k);
      repeat (k) @(posedge core_clk);
      @(negedge core_clk);
   endtask : settle

   task automatic tdone(input string s);
      $display("test %s done, mismatches so far %0d", s, mismatches);
   endtask : tdone

   task automatic complete_run();
      $display("compared %0d, mismatched %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   // ----------------
   // Scenarios
   // ----------------
   initial begin
      int k, n, l;
      logic [7:0] l8, held;
      void'($urandom(32'hF3D1));
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      settle(2);
      check(drive_mode, MODE_STANDBY);
      check(standby_q, 1'b1);
      check(dir_q, DIR_RESET);
      tdone("reset");
      @(posedge core_clk);
      start_n <= 1'b0;
      cmd_sel <= 2'h1;
      drive_req <= 6'h01;
      settle(4200);
      check(cmd_duty, DUTY_FULL);
      check(drive_mode, MODE_NORMAL);
      @(posedge core_clk);
      start_n <= 1'b1;
      settle(0);
      check(drive_mode, MODE_NORMAL);
      settle(4);
      check(drive_mode, MODE_STANDBY);
      @(posedge core_clk);
      start_n <= 1'b0;
      settle(12);
      tdone("duty full and sync");
      // Hand phase A over and back, counting all-off clocks
      for (k = 0; k < 2; k++) begin
         @(posedge core_clk);
         drive_req <= k ? 6'h01 : 6'h08;
         n = 0;
         repeat (30) begin
            @(negedge core_clk);
            if (gate === 6'h00) n++;
         end
         check(n, DEAD_REF_PERIODS);
         check(gate, k ? 6'h01 : 6'h08);
      end
      tdone("dead interval");
      for (k = 0; k < 64; k++) begin
         @(posedge core_clk);
         {start_n, brake_n, fault_raw} <= k[5:0];
         settle(14);
         check(drive_mode, exp_mode(k[5], k[4], k[3:0], 1'b0));
         check(standby_q, k[5]);
         if (exp_mode(k[5], k[4], k[3:0], 1'b0) == MODE_BRAKE) begin
            check(gate, 6'h07);
         end
      end
      @(posedge core_clk);
      {start_n, brake_n, fault_raw} <= 6'h10;
      tdone("mode table");
      @(posedge cp_clk);
      #1 l = cycles;
      @(posedge cp_clk);
      #1 check(cycles - l, CP_DIVIDE);
      @(posedge core_clk);
      hall_open_raw <= 1'b1;
      settle(8);
      check(gate_oe, 1'b0);
      @(posedge core_clk);
      hall_open_raw <= 1'b0;
      dir_pin <= 1'b0;
      settle(8);
      check(gate_oe, 1'b1);
      check(dir_q, 1'b0);
      @(posedge core_clk);
      dir_pin <= 1'b1;
      settle(8);
      check(dir_q, 1'b1);
      check(pulse_oe, 1'b1);
      check(pulse_q, 1'b0);
      @(posedge core_clk);
      hall_hold <= 3'h1;
      settle(6);
      check(pulse_oe, 1'b0);
      @(posedge core_clk);
      hall_hold <= 3'h0;
      start_n <= 1'b1;
      settle(6);
      check(pulse_oe, 1'b0);
      @(posedge core_clk);
      start_n <= 1'b0;
      hall_hold <= 3'h7;
      settle(6);
      check(hall_latched, 3'h7);
      tdone("pins and hall pulse");
      for (k = 0; k < 3; k++) begin
         @(posedge core_clk);
         mode_180 <= 1'b1;
         hall_hold <= (k == 2) ? 3'h3 : (k == 1) ? 3'h7 : 3'h1;
         settle(6);
         check(hall_latched, (k == 2) ? 3'h3 : 3'h1);
      end
      @(posedge core_clk);
      mode_180 <= 1'b0;
      cmd_sel <= 2'h2;
      l8 = 8'(20 + $urandom % 200);
      cmd_low <= l8;
      settle(3100);
      check(cmd_duty + 8'h01 >= l8 && cmd_duty <= l8 + 8'h01, 1);
      held = cmd_duty;
      @(posedge core_clk);
      mode_180 <= 1'b1;
      cmd_low <= l8 + 8'h01;
      settle(3100);
      check(cmd_duty, held);
      @(posedge core_clk);
      cmd_low <= l8 + 8'h06;
      settle(3100);
      check(cmd_duty >= l8 + 8'h05 && cmd_duty <= l8 + 8'h07, 1);
      @(posedge core_clk);
      mode_180 <= 1'b0;
      hall_run <= 1'b1;
      tdone("speed duty");
      // Pulses launched before the mode drop must drain first
      settle(3);
      l = ftv_cnt;
      settle(500);
      check(ftv_cnt - l, 0);
      @(posedge core_clk);
      mode_180 <= 1'b1;
      settle(0);
      l = ftv_cnt;
      settle(40);
      check(ftv_cnt - l, 0);
      settle(1500);
      check(ftv_cnt > l, 1);
      tdone("freq to voltage");
      for (k = 0; k < 2; k++) begin
         @(posedge core_clk);
         lead_angle_in <= k ? 5'h07 : 5'h1C;
         @(negedge core_clk);
         while (rises % 16 != 15) @(negedge core_clk);
         check(lead_step, exp_lead);
         while (rises % 16 != 0) @(negedge core_clk);
         settle(3);
         check(lead_step, exp_lead);
      end
      tdone("lead angle");
      @(posedge core_clk);
      hall_run <= 1'b0;
      cmd_sel <= 2'h0;
      settle(4300);
      check(cmd_duty, DUTY_RESET);
      check({dz, lock_rel}, 2'h3);
      check(drive_mode, exp_mode(1'b0, 1'b1, 4'h0, 1'b1));
      tdone("zero duty");
      complete_run();
   end
endmodule : bldc_drive_control_tb
`default_nettype wire
